// >>> tsr_top.sv
// Register file, conversion sequencing and alert logic of the temperature sensor
`timescale 1ns/1ns

module tsr_top #(
   parameter logic [26:0] CONV_CYCLES = tsr_pkg::CONV_CYC,
   parameter logic [26:0] PERIOD0     = tsr_pkg::PER0_CYC,
   parameter logic [26:0] PERIOD1     = tsr_pkg::PER1_CYC,
   parameter logic [26:0] PERIOD2     = tsr_pkg::PER2_CYC,
   parameter logic [26:0] PERIOD3     = tsr_pkg::PER3_CYC
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        link_clock,
   input  wire logic        link_cmd_valid,
   input  wire logic [1:0]  link_cmd,
   input  wire logic [7:0]  link_cmd_data,
   output logic             link_busy,
   output logic [7:0]       link_rd_data,
   input  wire logic [12:0] temp_sample,
   output logic             alert_o,
   output logic             alert_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic                 l_req_q;
   logic [1:0]           l_cmd_q;
   logic [7:0]           l_data_q;
   logic                 l_ack_s1_q;
   logic                 l_ack_s2_q;
   logic                 l_ack_s3_q;
   logic [7:0]           l_rd_q;
   logic                 c_req_s1_q;
   logic                 c_req_s2_q;
   logic                 c_req_s3_q;
   logic                 c_ack_q;
   logic [7:0]           c_rd_byte_q;
   logic [12:0]          samp_s1_q;
   logic [12:0]          samp_s2_q;
   logic [7:0]           ptr_q;
   logic                 idx_q;
   logic [15:0]          low_q;
   logic [15:0]          high_q;
   logic [12:0]          temp_raw_q;
   logic                 ready_q;
   logic [1:0]           fq_q;
   logic                 polar_q;
   logic                 intr_q;
   logic                 pdown_q;
   logic [1:0]           cr_q;
   logic                 wide_q;
   tsr_pkg::tsr_state_t  state_q;
   logic [26:0]          cnt_q;
   logic                 shot_q;
   logic                 cmp_q;
   logic [2:0]           fcnt_q;
   logic                 int_q;
   logic                 alert_oe_q;
   logic                 cmd_evt;
   logic                 rd_evt;
   logic                 wr_evt;
   logic                 ptr_evt;
   logic                 frm_evt;
   logic [1:0]           sel;
   logic                 status_bit;
   logic [15:0]          temp_word;
   logic [15:0]          cfg_word;
   logic [15:0]          rd_word;
   logic                 shot_wr;
   logic                 conv_end;
   logic                 shut_clr;
   logic [26:0]          period;
   logic signed [12:0]   t_cmp;
   logic signed [12:0]   hi_cmp;
   logic signed [12:0]   lo_cmp;
   logic                 cond;
   logic [2:0]           need;
   logic [2:0]           fcnt_nx;
   logic                 trip;
   logic                 alert_act;

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: hold a command and toggle a request; take the answer byte
   always_ff @(posedge link_clock or posedge rst) begin
      if (rst) begin
         l_req_q  <= 1'b0;
         l_cmd_q  <= tsr_pkg::CMD_FRAME;
         l_data_q <= 8'h00;
      end else if (link_cmd_valid && !link_busy) begin
         l_req_q  <= ~l_req_q;
         l_cmd_q  <= link_cmd;
         l_data_q <= link_cmd_data;
      end
   end

   always_ff @(posedge link_clock or posedge rst) begin
      if (rst) begin
         l_ack_s1_q <= 1'b0;
         l_ack_s2_q <= 1'b0;
         l_ack_s3_q <= 1'b0;
      end else begin
         l_ack_s1_q <= c_ack_q;
         l_ack_s2_q <= l_ack_s1_q;
         l_ack_s3_q <= l_ack_s2_q;
      end
   end

   // Answer byte is stable in the core until the next request
   always_ff @(posedge link_clock or posedge rst) begin
      if (rst) begin
         l_rd_q <= 8'h00;
      end else if (l_ack_s2_q ^ l_ack_s3_q) begin
         l_rd_q <= c_rd_byte_q;
      end
   end

   assign link_busy    = l_req_q ^ l_ack_s3_q;
   assign link_rd_data = l_rd_q;

   ////////////////////////////////////////////////////////////////////////////
   // Core domain: request synchroniser and temperature input synchroniser
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         c_req_s1_q <= 1'b0;
         c_req_s2_q <= 1'b0;
         c_req_s3_q <= 1'b0;
         samp_s1_q  <= 13'h0000;
         samp_s2_q  <= 13'h0000;
      end else begin
         c_req_s1_q <= l_req_q;
         c_req_s2_q <= c_req_s1_q;
         c_req_s3_q <= c_req_s2_q;
         samp_s1_q  <= temp_sample;
         samp_s2_q  <= samp_s1_q;
      end
   end

   // Link command fields are held stable across the handshake
   assign cmd_evt = c_req_s2_q ^ c_req_s3_q;
   assign rd_evt  = cmd_evt && (l_cmd_q == tsr_pkg::CMD_RD);
   assign wr_evt  = cmd_evt && (l_cmd_q == tsr_pkg::CMD_WR);
   assign ptr_evt = cmd_evt && (l_cmd_q == tsr_pkg::CMD_PTR);
   assign frm_evt = cmd_evt && (l_cmd_q == tsr_pkg::CMD_FRAME);
   assign sel     = ptr_q[1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Register read path
   assign status_bit = ~cmp_q ^ polar_q;
   assign temp_word  = wide_q ? {temp_raw_q, tsr_pkg::EXT_FILL}
                              : {temp_raw_q[11:0], tsr_pkg::NRM_FILL};
   assign cfg_word   = {ready_q, tsr_pkg::RES_BITS, fq_q, polar_q, intr_q, pdown_q,
                        cr_q, status_bit, wide_q, 4'h0};

   always_comb begin
      case (sel)
         tsr_pkg::REG_TEMP: rd_word = temp_word;
         tsr_pkg::REG_CFG:  rd_word = cfg_word;
         tsr_pkg::REG_LOW:  rd_word = low_q;
         default:           rd_word = high_q;
      endcase
   end

   // Every command is acknowledged; reads also load the answer byte
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         c_ack_q     <= 1'b0;
         c_rd_byte_q <= 8'h00;
      end else begin
         if (cmd_evt) begin
            c_ack_q <= ~c_ack_q;
         end
         if (rd_evt) begin
            c_rd_byte_q <= idx_q ? rd_word[7:0] : rd_word[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pointer and byte index
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ptr_q <= 8'h00;
         idx_q <= 1'b0;
      end else begin
         if (ptr_evt) begin
            ptr_q <= l_data_q;
         end
         if (ptr_evt || frm_evt) begin
            idx_q <= 1'b0;
         end else if (rd_evt || wr_evt) begin
            idx_q <= ~idx_q;
         end
      end
   end

   // Limits, written one byte at a time; temperature ignores writes
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         low_q  <= tsr_pkg::LOW_RST;
         high_q <= tsr_pkg::HIGH_RST;
      end else if (wr_evt) begin
         if (sel == tsr_pkg::REG_LOW && !idx_q) begin
            low_q[15:8] <= l_data_q;
         end
         if (sel == tsr_pkg::REG_LOW && idx_q) begin
            low_q[7:0] <= l_data_q;
         end
         if (sel == tsr_pkg::REG_HIGH && !idx_q) begin
            high_q[15:8] <= l_data_q;
         end
         if (sel == tsr_pkg::REG_HIGH && idx_q) begin
            high_q[7:0] <= l_data_q;
         end
      end
   end

   // Configuration fields; resolution and alert status are not writable
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fq_q    <= tsr_pkg::FQ_RST;
         polar_q <= 1'b0;
         intr_q  <= 1'b0;
         pdown_q <= 1'b0;
         cr_q    <= tsr_pkg::CR_RST;
         wide_q  <= 1'b0;
      end else if (wr_evt && sel == tsr_pkg::REG_CFG) begin
         if (!idx_q) begin
            fq_q    <= l_data_q[tsr_pkg::FQ_LSB +: 2];
            polar_q <= l_data_q[tsr_pkg::POLAR_BIT];
            intr_q  <= l_data_q[tsr_pkg::MODE_BIT];
            pdown_q <= l_data_q[tsr_pkg::PDOWN_BIT];
         end else begin
            cr_q    <= l_data_q[tsr_pkg::CR_LSB +: 2];
            wide_q  <= l_data_q[tsr_pkg::WIDE_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencing
   assign shot_wr  = wr_evt && sel == tsr_pkg::REG_CFG && !idx_q
                     && l_data_q[tsr_pkg::SHOT_BIT];
   assign conv_end = (state_q == tsr_pkg::ST_CONV) && (cnt_q == CONV_CYCLES - 27'h1);
   assign shut_clr = (conv_end && pdown_q && !shot_q)
                     || (state_q == tsr_pkg::ST_WAIT && pdown_q);

   always_comb begin
      case (cr_q)
         2'h0:    period = PERIOD0;
         2'h1:    period = PERIOD1;
         2'h2:    period = PERIOD2;
         default: period = PERIOD3;
      endcase
   end

   // Power-up starts a conversion at once
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= tsr_pkg::ST_CONV;
         cnt_q   <= 27'h0000000;
         shot_q  <= 1'b0;
      end else begin
         case (state_q)
            tsr_pkg::ST_SHUT: begin
               if (!pdown_q) begin
                  state_q <= tsr_pkg::ST_CONV;
                  cnt_q   <= 27'h0000000;
                  shot_q  <= 1'b0;
               end else if (shot_wr) begin
                  state_q <= tsr_pkg::ST_CONV;
                  cnt_q   <= 27'h0000000;
                  shot_q  <= 1'b1;
               end
            end
            tsr_pkg::ST_CONV: begin
               cnt_q <= cnt_q + 27'h1;
               if (conv_end) begin
                  shot_q <= 1'b0;
                  if (shot_q || pdown_q) begin
                     state_q <= tsr_pkg::ST_SHUT;
                  end else begin
                     state_q <= tsr_pkg::ST_WAIT;
                  end
               end
            end
            tsr_pkg::ST_WAIT: begin
               cnt_q <= cnt_q + 27'h1;
               if (pdown_q) begin
                  state_q <= tsr_pkg::ST_SHUT;
               end else if (cnt_q >= period - 27'h1) begin
                  state_q <= tsr_pkg::ST_CONV;
                  cnt_q   <= 27'h0000000;
               end
            end
            default: begin
               state_q <= tsr_pkg::ST_CONV;
               cnt_q   <= 27'h0000000;
               shot_q  <= 1'b0;
            end
         endcase
      end
   end

   // One-shot flag doubles as conversion ready
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ready_q <= 1'b0;
      end else if (state_q == tsr_pkg::ST_SHUT && pdown_q && shot_wr) begin
         ready_q <= 1'b0;
      end else if (conv_end && shot_q) begin
         ready_q <= 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         temp_raw_q <= 13'h0000;
      end else if (conv_end) begin
         temp_raw_q <= samp_s2_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Limit comparison and fault queue
   assign t_cmp  = wide_q ? signed'(samp_s2_q)
                          : signed'({samp_s2_q[11], samp_s2_q[11:0]});
   assign hi_cmp = wide_q ? signed'(high_q[15:3]) : signed'({high_q[15], high_q[15:4]});
   assign lo_cmp = wide_q ? signed'(low_q[15:3]) : signed'({low_q[15], low_q[15:4]});
   assign cond   = cmp_q ? (t_cmp < lo_cmp) : (t_cmp >= hi_cmp);

   always_comb begin
      case (fq_q)
         2'h0:    need = tsr_pkg::FQ_N0;
         2'h1:    need = tsr_pkg::FQ_N1;
         2'h2:    need = tsr_pkg::FQ_N2;
         default: need = tsr_pkg::FQ_N3;
      endcase
   end

   assign fcnt_nx = fcnt_q + 3'h1;
   assign trip    = conv_end && cond && (fcnt_nx >= need);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmp_q  <= 1'b0;
         fcnt_q <= 3'h0;
      end else if (conv_end) begin
         if (trip) begin
            cmp_q  <= ~cmp_q;
            fcnt_q <= 3'h0;
         end else if (cond) begin
            fcnt_q <= fcnt_nx;
         end else begin
            fcnt_q <= 3'h0;
         end
      end
   end

   // Latched alert; a new trip wins over a clear in the same cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         int_q <= 1'b0;
      end else if (trip) begin
         int_q <= 1'b1;
      end else if (rd_evt || shut_clr) begin
         int_q <= 1'b0;
      end
   end

   assign alert_act = intr_q ? int_q : cmp_q;

   // Open-drain pin: drive low when the pin level is low
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         alert_oe_q <= 1'b0;
      end else begin
         alert_oe_q <= alert_act ^ polar_q;
      end
   end

   assign alert_o  = 1'b0;
   assign alert_oe = alert_oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_shot_conv;
      (state_q == tsr_pkg::ST_CONV) && shot_q;
   endsequence

   sequence s_shot_done;
      (state_q == tsr_pkg::ST_SHUT) && ready_q;
   endsequence

   property p_rdy_busy;
      @(posedge clock) disable iff (rst) s_shot_conv |-> !ready_q;
   endproperty
   a_rdy_busy: assert property (p_rdy_busy) else $error("ready flag set too early");

   property p_shot_end;
      @(posedge clock) disable iff (rst) s_shot_conv ##0 conv_end |=> s_shot_done;
   endproperty
   a_shot_end: assert property (p_shot_end) else $error("one-shot did not return");

   property p_conv_len;
      @(posedge clock) disable iff (rst)
         (state_q == tsr_pkg::ST_CONV) |-> (cnt_q < CONV_CYCLES);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion overran");

   property p_temp_msb;
      @(posedge clock) disable iff (rst)
         rd_evt && sel == tsr_pkg::REG_TEMP && !idx_q && !conv_end
         |=> c_rd_byte_q == temp_word[15:8];
   endproperty
   a_temp_msb: assert property (p_temp_msb) else $error("temperature MSB wrong");

   property p_res_ro;
      @(posedge clock) disable iff (rst)
         rd_evt && sel == tsr_pkg::REG_CFG && !idx_q |=> c_rd_byte_q[6:5] == 2'h3;
   endproperty
   a_res_ro: assert property (p_res_ro) else $error("resolution bits wrong");

   property p_cmp_pin;
      @(posedge clock) disable iff (rst)
         !intr_q |=> alert_oe == ($past(cmp_q) ^ $past(polar_q));
   endproperty
   a_cmp_pin: assert property (p_cmp_pin) else $error("comparator pin wrong");

   property p_int_clr;
      @(posedge clock) disable iff (rst) rd_evt && !trip |=> !int_q;
   endproperty
   a_int_clr: assert property (p_int_clr) else $error("latched alert not cleared");

   property p_fault_rst;
      @(posedge clock) disable iff (rst) conv_end && !cond |=> fcnt_q == 3'h0;
   endproperty
   a_fault_rst: assert property (p_fault_rst) else $error("fault run not restarted");

   property p_temp_ro;
      @(posedge clock) disable iff (rst)
         wr_evt && sel == tsr_pkg::REG_TEMP && !conv_end |=> $stable(temp_raw_q);
   endproperty
   a_temp_ro: assert property (p_temp_ro) else $error("temperature was written");

   property p_pd_wait;
      @(posedge clock) disable iff (rst)
         (state_q == tsr_pkg::ST_WAIT) && pdown_q |=> state_q == tsr_pkg::ST_SHUT;
   endproperty
   a_pd_wait: assert property (p_pd_wait) else $error("power-down not entered");

endmodule

// >>> tsr_pkg.sv
// Constants and types shared by the temperature sensor register and alert logic
package tsr_pkg;

   // Clock and timing
   localparam int          CLK_HZ      = 20_000_000;
   localparam int          CYC_PER_MS  = CLK_HZ / 1000;
   localparam int          CONV_MS     = 26;
   localparam int          PER0_MS     = 4000;
   localparam int          PER1_MS     = 1000;
   localparam int          PER2_MS     = 250;
   localparam int          PER3_MS     = 125;
   localparam logic [26:0] CONV_CYC    = 27'(CONV_MS * CYC_PER_MS);
   localparam logic [26:0] PER0_CYC    = 27'(PER0_MS * CYC_PER_MS);
   localparam logic [26:0] PER1_CYC    = 27'(PER1_MS * CYC_PER_MS);
   localparam logic [26:0] PER2_CYC    = 27'(PER2_MS * CYC_PER_MS);
   localparam logic [26:0] PER3_CYC    = 27'(PER3_MS * CYC_PER_MS);

   // Register select codes
   localparam logic [1:0]  REG_TEMP    = 2'h0;
   localparam logic [1:0]  REG_CFG     = 2'h1;
   localparam logic [1:0]  REG_LOW     = 2'h2;
   localparam logic [1:0]  REG_HIGH    = 2'h3;

   // Link commands
   localparam logic [1:0]  CMD_FRAME   = 2'h0;
   localparam logic [1:0]  CMD_PTR     = 2'h1;
   localparam logic [1:0]  CMD_WR      = 2'h2;
   localparam logic [1:0]  CMD_RD      = 2'h3;

   // First configuration byte fields
   localparam int          SHOT_BIT    = 7;
   localparam int          FQ_LSB      = 3;
   localparam int          POLAR_BIT   = 2;
   localparam int          MODE_BIT    = 1;
   localparam int          PDOWN_BIT   = 0;
   // Second configuration byte fields
   localparam int          CR_LSB      = 6;
   localparam int          WIDE_BIT    = 4;

   // Reset and fixed values
   localparam logic [1:0]  RES_BITS    = 2'h3;
   localparam logic [1:0]  CR_RST      = 2'h2;
   localparam logic [1:0]  FQ_RST      = 2'h0;
   localparam logic [15:0] LOW_RST     = 16'h4b00;
   localparam logic [15:0] HIGH_RST    = 16'h5000;
   localparam logic [2:0]  EXT_FILL    = 3'h1;
   localparam logic [3:0]  NRM_FILL    = 4'h0;

   // Consecutive faults per fault-count code
   localparam logic [2:0]  FQ_N0       = 3'h1;
   localparam logic [2:0]  FQ_N1       = 3'h2;
   localparam logic [2:0]  FQ_N2       = 3'h4;
   localparam logic [2:0]  FQ_N3       = 3'h6;

   typedef enum logic [2:0] {
      ST_SHUT = 3'b001,
      ST_CONV = 3'b010,
      ST_WAIT = 3'b100
   } tsr_state_t;

endpackage

// >>> tsr_link_model.sv
// Link-side bus master model issuing one command at a time
`timescale 1ns/1ns
module tsr_link_model (
   input  wire logic       link_clock,
   input  wire logic       link_busy,
   input  wire logic [7:0] link_rd_data,
   output logic            link_cmd_valid,
   output logic [1:0]      link_cmd,
   output logic [7:0]      link_cmd_data
);
   int late_total;
   initial begin
      late_total = 0;
      link_cmd_valid = 1'b0;
      link_cmd = 2'h0;
      link_cmd_data = 8'h00;
   end
   // Hold the request until taken, then wait a bounded time for the answer
   task automatic send(input logic [1:0] c, input logic [7:0] d, output logic [7:0] rd);
      int n;
      @(posedge link_clock);
      #1;
      link_cmd_valid = 1'b1;
      link_cmd = c;
      link_cmd_data = d;
      do @(posedge link_clock); while (link_busy !== 1'b0);
      #1;
      link_cmd_valid = 1'b0;
      // Released data shows the inverse so a stale byte cannot pass
      link_cmd_data = ~d;
      repeat (2) @(posedge link_clock);
      n = 0;
      while (link_busy !== 1'b0 && n < 20) begin
         @(posedge link_clock);
         n++;
      end
      // A missing answer is counted by the bench as a mismatch
      if (link_busy !== 1'b0) begin
         late_total++;
      end
      rd = link_rd_data;
   endtask
endmodule

// >>> temp_sensor_regs_alert_test.sv
// Self-checking bench: registers, conversions, alert modes and one-shot
`timescale 1ns/1ns
module temp_sensor_regs_alert_test;
   logic        clock;
   logic        rst;
   logic        link_clock;
   logic        link_cmd_valid;
   logic [1:0]  link_cmd;
   logic [7:0]  link_cmd_data;
   logic        link_busy;
   logic [7:0]  link_rd_data;
   logic [12:0] temp_sample;
   logic        alert_o;
   logic        alert_oe;
   logic [15:0] v;
   logic [7:0]  b;
   int          err_total;
   int          n_compared;
   int          cyc;
   int          t0;

   tsr_top #(.CONV_CYCLES(27'd40), .PERIOD0(27'd160), .PERIOD1(27'd120),
      .PERIOD2(27'd90), .PERIOD3(27'd70)) u_dut (
      .clock(clock), .rst(rst), .link_clock(link_clock),
      .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd),
      .link_cmd_data(link_cmd_data), .link_busy(link_busy),
      .link_rd_data(link_rd_data), .temp_sample(temp_sample),
      .alert_o(alert_o), .alert_oe(alert_oe));
   tsr_link_model u_link (.link_clock(link_clock), .link_busy(link_busy),
      .link_rd_data(link_rd_data), .link_cmd_valid(link_cmd_valid),
      .link_cmd(link_cmd), .link_cmd_data(link_cmd_data));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      link_clock = 1'b0;
      #7;
      forever #15 link_clock = ~link_clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] tfmt(input logic [12:0] t, input bit wide);
      return wide ? {t, 3'h1} : {t[11:0], 4'h0};
   endfunction
   task automatic wr(input logic [1:0] r, input logic [15:0] d);
      u_link.send(tsr_pkg::CMD_PTR, {6'h00, r}, b);
      u_link.send(tsr_pkg::CMD_WR, d[15:8], b);
      u_link.send(tsr_pkg::CMD_WR, d[7:0], b);
   endtask
   task automatic rd(input logic [1:0] r, output logic [15:0] d);
      u_link.send(tsr_pkg::CMD_PTR, {6'h00, r}, b);
      u_link.send(tsr_pkg::CMD_RD, 8'h00, d[15:8]);
      u_link.send(tsr_pkg::CMD_RD, 8'h00, d[7:0]);
   endtask
   task automatic settle(input logic [12:0] t, input int n);
      @(negedge clock);
      temp_sample = t;
      repeat (n) @(negedge clock);
   endtask
   task automatic end_of_test;
      err_total += u_link.late_total;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      void'($urandom(32'heca1c3f7));
      t0 = $urandom_range(0, 32'h4af);
      temp_sample = 13'(t0);
      repeat (4) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      repeat (100) @(negedge clock);
      // Unpointed read returns the temperature result
      u_link.send(tsr_pkg::CMD_RD, 8'h00, v[15:8]);
      u_link.send(tsr_pkg::CMD_RD, 8'h00, v[7:0]);
      check(v, tfmt(13'(t0), 0));
      rd(tsr_pkg::REG_CFG, v);
      check(v, 16'h60a0);
      rd(tsr_pkg::REG_LOW, v);
      check(v, tsr_pkg::LOW_RST);
      rd(tsr_pkg::REG_HIGH, v);
      check(v, tsr_pkg::HIGH_RST);
      check({15'h0, alert_oe}, 16'h0);
      check({15'h0, alert_o}, 16'h0);
      $display("test reset done");
      wr(tsr_pkg::REG_CFG, 16'h88ff);
      rd(tsr_pkg::REG_CFG, v);
      check(v, 16'h68f0);
      t0 = $urandom_range(0, 32'h4af);
      settle(13'(t0), 200);
      rd(tsr_pkg::REG_TEMP, v);
      check(v, tfmt(13'(t0), 1));
      wr(tsr_pkg::REG_CFG, 16'h08c0);
      wr(tsr_pkg::REG_HIGH, 16'h1000);
      wr(tsr_pkg::REG_LOW, 16'h0800);
      $display("test config done");
      settle(13'h0180, 250);
      check({15'h0, alert_oe}, 16'h1);
      rd(tsr_pkg::REG_CFG, v);
      check(v, 16'h68c0);
      settle(13'h00c0, 250);
      check({15'h0, alert_oe}, 16'h1);
      settle(13'h0040, 250);
      check({15'h0, alert_oe}, 16'h0);
      wr(tsr_pkg::REG_CFG, 16'h0cc0);
      rd(tsr_pkg::REG_CFG, v);
      check(v, 16'h6cc0);
      check({15'h0, alert_oe}, 16'h1);
      $display("test comparator done");
      wr(tsr_pkg::REG_CFG, 16'h0ac0);
      settle(13'h0180, 250);
      check({15'h0, alert_oe}, 16'h1);
      rd(tsr_pkg::REG_TEMP, v);
      check(v, tfmt(13'h0180, 0));
      settle(13'h0180, 250);
      check({15'h0, alert_oe}, 16'h0);
      settle(13'h0040, 250);
      check({15'h0, alert_oe}, 16'h1);
      rd(tsr_pkg::REG_CFG, v);
      check(v, 16'h6ae0);
      settle(13'h0040, 5);
      check({15'h0, alert_oe}, 16'h0);
      settle(13'h0180, 250);
      check({15'h0, alert_oe}, 16'h1);
      wr(tsr_pkg::REG_CFG, 16'h0bc0);
      settle(13'h0180, 50);
      check({15'h0, alert_oe}, 16'h0);
      $display("test interrupt done");
      wr(tsr_pkg::REG_CFG, 16'h01c0);
      check({15'h0, alert_oe}, 16'h1);
      t0 = $urandom_range(32'h081, 32'h0ff);
      settle(13'(t0), 300);
      rd(tsr_pkg::REG_TEMP, v);
      check(v, tfmt(13'h0180, 0));
      wr(tsr_pkg::REG_CFG, 16'h81c0);
      rd(tsr_pkg::REG_CFG, v);
      check(v, 16'h61c0);
      settle(13'(t0), 100);
      rd(tsr_pkg::REG_CFG, v);
      check(v, 16'he1c0);
      rd(tsr_pkg::REG_TEMP, v);
      check(v, tfmt(13'(t0), 0));
      settle(13'h0050, 300);
      rd(tsr_pkg::REG_TEMP, v);
      check(v, tfmt(13'(t0), 0));
      wr(tsr_pkg::REG_TEMP, 16'hffff);
      rd(tsr_pkg::REG_TEMP, v);
      check(v, tfmt(13'(t0), 0));
      $display("test one-shot done");
      end_of_test();
   end
endmodule
